/* include/bscc_pkg.sv */
/*
  Package for the bit-skip and call control block: widths, opcode kinds,
  state encoding and the carrier structs shared by the control and stack files.
  Assumes one instruction clock and a 10-bit program counter.
*/
package bscc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PC_W = 10;
  localparam int DATA_W = 8;
  localparam int BIT_SEL_W = 3;
  localparam int REG_ADDR_W = 6;
  localparam int STACK_DEPTH = 4;
  localparam int SP_W = 2;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;
  localparam logic [PC_W-1:0] PC_STEP = 10'h001;
  localparam logic [SP_W-1:0] SP_RESET = 2'h0;
  localparam logic [SP_W-1:0] SP_STEP = 2'h1;
  localparam int HI_LSB = 0;
  localparam int HI_MSB = 1;

  // ----------------------------------------------------------------
  // Instruction kinds handled here
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BSCC_OP_NONE = 3'h0,
    BSCC_OP_SKIP_CLEAR = 3'h1,
    BSCC_OP_SKIP_SET = 3'h2,
    BSCC_OP_CALL_IMM = 3'h3,
    BSCC_OP_CALL_ACC = 3'h4
  } bscc_op_e;

  // Execution states; RUN-FLUSH moves change one bit, RUN-CALL2 moves change two
  typedef enum logic [1:0] {
    BSCC_ST_RUN = 2'b00,
    BSCC_ST_FLUSH = 2'b01,
    BSCC_ST_CALL2 = 2'b11
  } bscc_state_e;

  // Decoded instruction from the core
  typedef struct packed {
    logic valid;
    bscc_op_e op;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [BIT_SEL_W-1:0] bit_sel;
    logic [DATA_W-1:0] imm_addr;
  } bscc_instr_s;

  // Stack write port
  typedef struct packed {
    logic push;
    logic [SP_W-1:0] ptr;
    logic [PC_W-1:0] data;
  } bscc_push_s;

endpackage

/* verilog/bscc_stack_mem.sv */
/*
  Return-address stack storage: one write port, one registered read port.
  Assumes the control file supplies the pointer and writes at most once a cycle.
*/
`timescale 1ns/1ns
`default_nettype none

module bscc_stack_mem
#(
  parameter int DEPTH = bscc_pkg::STACK_DEPTH,
  parameter int AW = bscc_pkg::SP_W,
  parameter int DW = bscc_pkg::PC_W
)
(
  input wire logic clock, // Instruction clock
  input wire logic rst_n, // Async reset, active low
  input wire bscc_pkg::bscc_push_s wr, // Push request
  input wire logic [AW-1:0] rd_ptr, // Read address
  output logic [DW-1:0] rd_data // Registered read data
);
  import bscc_pkg::*;

  logic [DW-1:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // Storage; no reset so it maps onto plain RAM
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (wr.push)
    begin
      mem[wr.ptr] <= wr.data;
    end
  end

  // Read data comes out of a register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data <= '0;
    end
    else
    begin
      rd_data <= mem[rd_ptr];
    end
  end

endmodule

`default_nettype wire

/* verilog/bscc_control.sv */
/*
  Control-flow executor for the two bit-test-and-skip instructions and the
  two subroutine calls of an 8-bit core, with its 10-bit program counter and
  return-address stack pointer.
  Assumes the core presents one decoded instruction per cycle when ready is
  high, returns the addressed register byte combinationally, and holds the
  accumulator, pc_high_buffer and table_high_pointer values itself.
*/
// Behaviour
// - Skip-if-clear reads chosen bit; skips next instruction when it is 0.
// - Skip-if-set reads chosen bit; skips next instruction when it is 1.
// - Skip discards prefetched word and runs a no-op cycle instead.
// - Bit tests take one cycle, or two when skipping.
// - Calls push PC plus one onto stack top; each takes two cycles.
// - Immediate call loads its 8-bit address into PC low byte.
// - Immediate call takes PC bits 9:8 from pc_high_buffer bits 1:0.
// - Accumulator call takes PC bits 9:8 from table_high_pointer bits 1:0.
// - Accumulator call loads the whole accumulator into PC low byte.
`timescale 1ns/1ns
`default_nettype none

module bscc_control
(
  input wire logic clock, // Instruction clock, 50 MHz
  input wire logic rst_n, // Async reset, active low
  input wire bscc_pkg::bscc_instr_s instr, // Decoded instruction
  input wire logic [bscc_pkg::DATA_W-1:0] reg_rd_data, // Addressed register byte
  input wire logic [bscc_pkg::DATA_W-1:0] accumulator, // Accumulator value
  input wire logic [bscc_pkg::DATA_W-1:0] pc_high_buffer, // PC high-byte buffer
  input wire logic [bscc_pkg::DATA_W-1:0] table_high_pointer, // Table high pointer
  output logic ready, // Next instruction may be presented
  output logic discard, // Prefetched word is being discarded
  output logic [bscc_pkg::REG_ADDR_W-1:0] reg_rd_addr, // Bit-test register address
  output logic [bscc_pkg::PC_W-1:0] pc, // Program counter
  output logic [bscc_pkg::SP_W-1:0] stack_ptr, // Return-stack pointer
  output logic [bscc_pkg::PC_W-1:0] stack_top, // Last written stack entry
  output logic flags_we, // Status flag write enable, never set here
  output logic acc_we // Accumulator write enable, never set here
);
  import bscc_pkg::*;

  bscc_state_e state_ff, nxt_state;
  logic [PC_W-1:0] pc_ff, nxt_pc;
  logic [SP_W-1:0] sp_ff;
  logic [PC_W-1:0] target_ff;
  bscc_push_s push;
  logic take;
  logic bit_val;
  logic skip;
  logic [PC_W-1:0] stack_rd;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Call target: two high bits from a holding register, low byte given
  function automatic logic [PC_W-1:0] call_target(input logic [DATA_W-1:0] hi, input logic [DATA_W-1:0] lo);
    call_target = {hi[HI_MSB:HI_LSB], lo};
  endfunction

  function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] p);
    pc_inc = p + PC_STEP;
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Register address goes straight to the file so the bit is back this cycle
  assign reg_rd_addr = instr.reg_addr;
  // Ready gates acceptance, so a word held across reset release is refused
  assign take = instr.valid && ready && (state_ff == BSCC_ST_RUN);
  assign bit_val = reg_rd_data[instr.bit_sel];
  always_comb
  begin
    skip = 1'b0;
    if (take && instr.op == BSCC_OP_SKIP_CLEAR && !bit_val)
    begin
      skip = 1'b1;
    end
    if (take && instr.op == BSCC_OP_SKIP_SET && bit_val)
    begin
      skip = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  // Calls and taken skips hold the pipe for a second cycle
  always_comb
  begin
    nxt_state = BSCC_ST_RUN;
    nxt_pc = pc_ff;
    push = '0;
    case (state_ff)
      BSCC_ST_RUN:
      begin
        if (take)
        begin
          nxt_pc = pc_inc(pc_ff);
          case (instr.op)
            BSCC_OP_SKIP_CLEAR, BSCC_OP_SKIP_SET:
            begin
              if (skip)
              begin
                nxt_state = BSCC_ST_FLUSH;
              end
            end
            BSCC_OP_CALL_IMM, BSCC_OP_CALL_ACC:
            begin
              push.push = 1'b1;
              push.ptr = sp_ff;
              push.data = pc_inc(pc_ff);
              nxt_state = BSCC_ST_CALL2;
            end
            default:
            begin
              nxt_state = BSCC_ST_RUN;
            end
          endcase
        end
      end
      BSCC_ST_FLUSH:
      begin
        // Discarded word only advances PC past itself
        nxt_pc = pc_inc(pc_ff);
      end
      BSCC_ST_CALL2:
      begin
        nxt_pc = target_ff;
      end
      default:
      begin
        nxt_state = BSCC_ST_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= BSCC_ST_RUN;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Program counter
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_ff <= PC_RESET;
    end
    else
    begin
      pc_ff <= nxt_pc;
    end
  end

  // Target captured in the first call cycle, so later changes to the
  // accumulator or high registers cannot bend the jump
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      target_ff <= PC_RESET;
    end
    else if (take && instr.op == BSCC_OP_CALL_IMM)
    begin
      target_ff <= call_target(pc_high_buffer, instr.imm_addr);
    end
    else if (take && instr.op == BSCC_OP_CALL_ACC)
    begin
      target_ff <= call_target(table_high_pointer, accumulator);
    end
  end

  // Stack pointer moves after the write into the entry it names
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sp_ff <= SP_RESET;
    end
    else if (push.push)
    begin
      sp_ff <= sp_ff + SP_STEP;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready <= 1'b0;
      discard <= 1'b0;
      flags_we <= 1'b0;
      acc_we <= 1'b0;
    end
    else
    begin
      ready <= (nxt_state == BSCC_ST_RUN);
      discard <= (nxt_state == BSCC_ST_FLUSH);
      flags_we <= 1'b0;
      acc_we <= 1'b0;
    end
  end

  assign pc = pc_ff;
  assign stack_ptr = sp_ff;
  assign stack_top = stack_rd;

  // Read port looks at the entry just written: pointer minus one
  bscc_stack_mem u_stack
  (
    .clock(clock),
    .rst_n(rst_n),
    .wr(push),
    .rd_ptr(sp_ff - SP_STEP),
    .rd_data(stack_rd)
  );

endmodule

`default_nettype wire

/* verification/bscc_control_asserts.sv */
/*
  Port checker for the bit-skip and call control block.
  Assumes it is bound to bscc_control; one clock, async reset.
*/
`timescale 1ns/1ns
`default_nettype none
module bscc_control_asserts
  import bscc_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic rst_n, // Reset, active low
  input wire bscc_instr_s instr, // Instruction
  input wire logic [DATA_W-1:0] reg_rd_data, // Register byte
  input wire logic [DATA_W-1:0] accumulator, // Accumulator
  input wire logic [DATA_W-1:0] pc_high_buffer, // PC high buffer
  input wire logic [DATA_W-1:0] table_high_pointer, // Table high
  input wire logic ready, // Ready
  input wire logic discard, // Discard
  input wire logic [PC_W-1:0] pc, // Program counter
  input wire logic [SP_W-1:0] stack_ptr, // Stack pointer
  input wire logic [PC_W-1:0] stack_top, // Stack top
  input wire logic flags_we, // Flag write
  input wire logic acc_we // Accumulator write
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // Only an instruction met by ready counts; others are refused
  wire logic go = ready && instr.valid;
  wire logic call = go && (instr.op == BSCC_OP_CALL_IMM || instr.op == BSCC_OP_CALL_ACC);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_skip_clear: assert property (go && instr.op == BSCC_OP_SKIP_CLEAR |=>
    discard == !$past(reg_rd_data[instr.bit_sel]) && pc == $past(pc) + PC_STEP) else $error("skip clear wrong");
  a_skip_set: assert property (go && instr.op == BSCC_OP_SKIP_SET |=>
    discard == $past(reg_rd_data[instr.bit_sel])) else $error("skip set wrong");
  a_discard_one: assert property (discard |=> !discard && ready && pc == $past(pc) + PC_STEP)
    else $error("no-op cycle wrong");
  a_call_push: assert property (call |=> !ready && !discard && stack_ptr == $past(stack_ptr) + SP_STEP)
    else $error("call push wrong");
  a_push_value: assert property (call |=> ##1 ready && stack_top == $past(pc, 2) + PC_STEP)
    else $error("return address wrong");
  a_imm_target: assert property (go && instr.op == BSCC_OP_CALL_IMM |=> ##1
    pc == {$past(pc_high_buffer[1:0], 2), $past(instr.imm_addr, 2)}) else $error("call target wrong");
  a_acc_target: assert property (go && instr.op == BSCC_OP_CALL_ACC |=> ##1
    pc == {$past(table_high_pointer[1:0], 2), $past(accumulator, 2)}) else $error("acc target wrong");
  a_no_flags: assert property (!flags_we) else $error("flags written");
  a_acc_kept: assert property (!acc_we) else $error("accumulator written");
endmodule
bind bscc_control bscc_control_asserts i_bscc_control_asserts (.clock, .rst_n, .instr, .reg_rd_data,
  .accumulator, .pc_high_buffer, .table_high_pointer, .ready, .discard, .pc, .stack_ptr, .stack_top,
  .flags_we, .acc_we);
`default_nettype wire

/* verification/bit_skip_and_call_control_bench.sv */
/*
  Self-checking bench: table of instructions, then a reset in mid-run.
  Assumes the package and checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module bit_skip_and_call_control_bench;
  import bscc_pkg::*;
  typedef struct packed {bscc_op_e op; logic [2:0] b; logic [7:0] d; logic [7:0] v; logic sk;} bscc_row_s;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  bscc_instr_s instr = '0;
  logic [DATA_W-1:0] reg_rd_data = '0, accumulator = '0, pc_high_buffer = '0, table_high_pointer = '0;
  logic ready, discard, flags_we, acc_we;
  logic [REG_ADDR_W-1:0] reg_rd_addr;
  logic [PC_W-1:0] pc, stack_top, exp_pc = PC_RESET;
  logic [SP_W-1:0] stack_ptr, exp_sp = SP_RESET;
  int error_cnt = 0;
  int num_checks = 0;
  `define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
  // Rows: op, bit, register byte, immediate or accumulator, skip expected
  bscc_row_s rows [12] = '{
    '{BSCC_OP_NONE, 3'h0, 8'h00, 8'h00, 1'b0}, '{BSCC_OP_SKIP_CLEAR, 3'h2, 8'h5a, 8'h00, 1'b1},
    '{BSCC_OP_SKIP_CLEAR, 3'h3, 8'h5a, 8'h00, 1'b0}, '{BSCC_OP_SKIP_SET, 3'h3, 8'h5a, 8'h00, 1'b1},
    '{BSCC_OP_SKIP_SET, 3'h0, 8'h5a, 8'h00, 1'b0}, '{BSCC_OP_SKIP_SET, 3'h7, 8'h80, 8'h00, 1'b1},
    '{BSCC_OP_SKIP_CLEAR, 3'h7, 8'h7f, 8'h00, 1'b1}, '{BSCC_OP_CALL_IMM, 3'h0, 8'hfd, 8'h34, 1'b0},
    '{BSCC_OP_CALL_ACC, 3'h0, 8'hfd, 8'hff, 1'b0}, '{BSCC_OP_CALL_IMM, 3'h0, 8'h03, 8'hff, 1'b0},
    '{BSCC_OP_NONE, 3'h0, 8'h00, 8'h00, 1'b0}, '{BSCC_OP_CALL_ACC, 3'h0, 8'h00, 8'h00, 1'b0}};

  bscc_control i_bscc_control (.clock, .rst_n, .instr, .reg_rd_data, .accumulator, .pc_high_buffer,
    .table_high_pointer, .ready, .discard, .reg_rd_addr, .pc, .stack_ptr, .stack_top, .flags_we, .acc_we);

  // ----------------------------------------
  // Clock, tasks, sequence
  // ----------------------------------------
  always #10 clock = ~clock;

  task automatic close_out;
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Called at a falling edge; rows follow back to back with no idle cycle
  task automatic run(input bscc_row_s r);
    logic call;
    logic [PC_W-1:0] tgt;
    begin
      call = r.op == BSCC_OP_CALL_IMM || r.op == BSCC_OP_CALL_ACC;
      tgt = r.op == BSCC_OP_CALL_IMM ? {r.d[1:0], r.v} : {~r.d[1:0], r.v};
      instr = '{1'b1, r.op, 6'h2a, r.b, r.op == BSCC_OP_CALL_ACC ? ~r.v : r.v};
      reg_rd_data = r.d;
      pc_high_buffer = r.d;
      table_high_pointer = ~r.d;
      accumulator = r.v;
      @(negedge clock);
      `CHK(reg_rd_addr, 6'h2a)
      `CHK(pc, exp_pc + PC_STEP)
      `CHK(discard, r.sk)
      `CHK(ready, !(r.sk || call))
      `CHK(stack_ptr, call ? exp_sp + SP_STEP : exp_sp)
      if (call || r.sk)
      begin
        // Scramble sources in the stall: target must come from the taking edge
        instr.op = BSCC_OP_CALL_IMM;
        accumulator = ~r.v;
        pc_high_buffer = ~r.d;
        table_high_pointer = r.d;
        @(negedge clock);
        `CHK(pc, call ? tgt : exp_pc + PC_STEP + PC_STEP)
        `CHK({ready, discard}, 2'b10)
        if (call) `CHK(stack_top, exp_pc + PC_STEP)
      end
      exp_sp = call ? exp_sp + SP_STEP : exp_sp;
      exp_pc = call ? tgt : r.sk ? exp_pc + PC_STEP + PC_STEP : exp_pc + PC_STEP;
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    `CHK(ready, 1'b1)
    foreach (rows[i]) run(rows[i]);
    rst_n = 1'b0;
    #1;
    `CHK({pc, stack_top, stack_ptr, ready, discard}, 24'h0)
    @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    `CHK(pc, PC_RESET)
    instr.valid = 1'b0;
    @(negedge clock);
    `CHK({pc, ready}, 11'h001)
    `CHK({flags_we, acc_we}, 2'b00)
    close_out;
  end

  // Watchdog: the run needs about 30 cycles
  initial
  begin
    #20000;
    error_cnt++;
    close_out;
  end
endmodule
`default_nettype wire
